// ---- hw/t2cru_pkg.sv ----
// t2cru_pkg: register map, field positions and counts of the timer unit
package t2cru_pkg;

  // register offsets
  localparam logic [7:0] ADDR_CTRL     = 8'hc8;
  localparam logic [7:0] ADDR_MODE     = 8'hc9;
  localparam logic [7:0] ADDR_RCAP_LO  = 8'hca;
  localparam logic [7:0] ADDR_RCAP_HI  = 8'hcb;
  localparam logic [7:0] ADDR_CNT_LO   = 8'hcc;
  localparam logic [7:0] ADDR_CNT_HI   = 8'hcd;
  localparam logic [7:0] ADDR_CLKCTL   = 8'he0;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'he1;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'he2;

  // timer_control fields
  localparam int CTL_OVF  = 7;
  localparam int CTL_EXT  = 6;
  localparam int CTL_RCLK = 5;
  localparam int CTL_TRANSMIT_CLOCK_SELECT = 4;
  localparam int CTL_EXEN = 3;
  localparam int CTL_RUN  = 2;
  localparam int CTL_CT   = 1;
  localparam int CTL_CPRL = 0;

  // timer_mode and clock control fields
  localparam int MODE_OE   = 1;
  localparam int MODE_DOWN_COUNT_ENABLE = 0;
  localparam int CKC_PRESC = 5;
  localparam int CKC_IEN   = 0;
  localparam logic [7:0] CKC_MASK = 8'h21;

  // event bits of the interrupt status register
  localparam int EV_OVF = 0;
  localparam int EV_EXT = 1;
  localparam int EV_CAP = 2;
  localparam int EV_RLD = 3;

  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0]  RST_NIB  = 4'h0;
  localparam logic [1:0]  RST_MODE = 2'h0;
  localparam logic [1:0]  RST_PIN  = 2'h3;

  // counts
  localparam logic [3:0]  PRE_SLOW = 4'hc;
  localparam logic [3:0]  PRE_FAST = 4'h4;
  localparam logic [15:0] CNT_TOP  = 16'hffff;

endpackage

// ---- hw/t2cru_pin_if.sv ----
// t2cru_pin_if: synchronised pin levels and edges for the timer core
`timescale 1ns/1ps
interface t2cru_pin_if;
  logic trig_lvl;
  logic trig_fall;
  logic cnt_fall;
  modport src (output trig_lvl, output trig_fall, output cnt_fall);
  modport dst (input trig_lvl, input trig_fall, input cnt_fall);
endinterface

// ---- hw/t2cru_pin_sync.sv ----
// t2cru_pin_sync: two-flop synchronisers and falling-edge detect
`timescale 1ns/1ps
module t2cru_pin_sync (
  // clock and reset
  input  logic      clk_sys,
  input  logic      arst_n,
  // pins, bit 0 trigger, bit 1 count
  input  logic      trig_pin,
  input  logic      count_pin,
  // to the core
  t2cru_pin_if.src  pins
);

  logic [1:0] s1_q;
  logic [1:0] s1_d;
  logic [1:0] s2_q;
  logic [1:0] s2_d;
  logic [1:0] s3_q;
  logic [1:0] s3_d;

  always_comb begin
    s1_d = {count_pin, trig_pin};
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // reset high so a pin that is already low at release is seen as a fall
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= t2cru_pkg::RST_PIN;
      s2_q <= t2cru_pkg::RST_PIN;
      s3_q <= t2cru_pkg::RST_PIN;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // edges taken from stage two onward only
  assign pins.trig_lvl  = s2_q[0];
  assign pins.trig_fall = s3_q[0] & ~s2_q[0];
  assign pins.cnt_fall  = s3_q[1] & ~s2_q[1];

endmodule

// ---- hw/t2cru_timer.sv ----
// t2cru_timer: timer/counter core with register port and interrupts
`timescale 1ns/1ps
module t2cru_timer (
  // clock and reset
  input  logic       clk_sys,
  input  logic       arst_n,
  // register port
  input  logic [7:0] reg_addr,
  input  logic [7:0] reg_wdata,
  input  logic       reg_wr,
  input  logic       reg_rd,
  output logic [7:0] reg_rdata,
  // pins
  input  logic       trig_pin,
  input  logic       count_pin,
  output logic       clk_out,
  output logic       clk_out_oe_n,
  // serial time base
  input  logic       t1_ovf,
  output logic       rx_tick,
  output logic       tx_tick,
  // interrupts
  output logic       timer_irq,
  output logic       irq
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  t2cru_pin_if pins ();

  logic [7:0]  ctl_q;
  logic [7:0]  ctl_d;
  logic [1:0]  mode_q;
  logic [1:0]  mode_d;
  logic [7:0]  ckc_q;
  logic [7:0]  ckc_d;
  logic [15:0] rcap_q;
  logic [15:0] rcap_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] cnt_hw;
  logic [3:0]  pre_q;
  logic [3:0]  pre_d;
  logic [3:0]  pre_lim;
  logic        clko_q;
  logic        clko_d;
  logic        rx_q;
  logic        rx_d;
  logic        tx_q;
  logic        tx_d;
  logic [3:0]  stat_q;
  logic [3:0]  stat_d;
  logic [3:0]  mask_q;
  logic [3:0]  mask_d;
  logic [3:0]  ev;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;

  logic wr_ctl;
  logic wr_mode;
  logic wr_rlo;
  logic wr_rhi;
  logic wr_clo;
  logic wr_chi;
  logic wr_ckc;
  logic wr_stat;
  logic wr_mask;
  logic baud;
  logic capmode;
  logic down_mode;
  logic down_dir;
  logic pre_tick;
  logic step;
  logic up_ovf;
  logic dn_hit;
  logic ovf_ev;
  logic trig_en;
  logic trig_act;
  logic do_cap;
  logic do_rld;
  logic tf_set;
  logic exf_set;

  function automatic logic wr_at(input logic wr, input logic [7:0] addr,
                                 input logic [7:0] off);
    return wr && (addr == off);
  endfunction

  t2cru_pin_sync u_sync (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .trig_pin  (trig_pin),
    .count_pin (count_pin),
    .pins      (pins)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode and mode

  assign wr_ctl  = wr_at(reg_wr, reg_addr, t2cru_pkg::ADDR_CTRL);
  assign wr_mode = wr_at(reg_wr, reg_addr, t2cru_pkg::ADDR_MODE);
  assign wr_rlo  = wr_at(reg_wr, reg_addr, t2cru_pkg::ADDR_RCAP_LO);
  assign wr_rhi  = wr_at(reg_wr, reg_addr, t2cru_pkg::ADDR_RCAP_HI);
  assign wr_clo  = wr_at(reg_wr, reg_addr, t2cru_pkg::ADDR_CNT_LO);
  assign wr_chi  = wr_at(reg_wr, reg_addr, t2cru_pkg::ADDR_CNT_HI);
  assign wr_ckc  = wr_at(reg_wr, reg_addr, t2cru_pkg::ADDR_CLKCTL);
  assign wr_stat = wr_at(reg_wr, reg_addr, t2cru_pkg::ADDR_IRQ_STAT);
  assign wr_mask = wr_at(reg_wr, reg_addr, t2cru_pkg::ADDR_IRQ_MASK);

  assign baud = ctl_q[t2cru_pkg::CTL_RCLK] | ctl_q[t2cru_pkg::CTL_TRANSMIT_CLOCK_SELECT];
  assign capmode = ctl_q[t2cru_pkg::CTL_CPRL] && !baud;
  // baud mode always counts up, so direction control is auto-reload only
  assign down_mode = mode_q[t2cru_pkg::MODE_DOWN_COUNT_ENABLE] && !capmode && !baud;
  assign down_dir  = down_mode && !pins.trig_lvl;

  assign pre_lim = ckc_q[t2cru_pkg::CKC_PRESC] ? t2cru_pkg::PRE_FAST
                                                : t2cru_pkg::PRE_SLOW;
  assign pre_tick = (pre_q >= (pre_lim - 4'h1));
  assign step = ctl_q[t2cru_pkg::CTL_RUN] &&
                (ctl_q[t2cru_pkg::CTL_CT] ? pins.cnt_fall
                                          : pre_tick);

  assign up_ovf = step && !down_dir && (cnt_q == t2cru_pkg::CNT_TOP);
  assign dn_hit = step && down_dir && (cnt_q == rcap_q);
  assign ovf_ev = up_ovf | dn_hit;

  // trigger pin drives direction while down-counting, so no reload then
  assign trig_en  = pins.trig_fall && ctl_q[t2cru_pkg::CTL_EXEN];
  assign trig_act = trig_en && !baud && !down_mode;
  assign do_cap   = trig_act && capmode;
  assign do_rld   = (trig_act || up_ovf) && !capmode;
  assign tf_set   = ovf_ev && !baud;
  assign exf_set  = trig_en && !mode_q[t2cru_pkg::MODE_DOWN_COUNT_ENABLE];

  ////////////////////////////////////////////////////////////////////////
  // timer core

  always_comb begin
    pre_d = pre_q + 4'h1;
    if (!ctl_q[t2cru_pkg::CTL_RUN] || ctl_q[t2cru_pkg::CTL_CT] ||
        pre_tick) begin
      pre_d = 4'h0;
    end
    cnt_hw = cnt_q;
    if (do_rld) begin
      cnt_hw = rcap_q;
    end else if (dn_hit) begin
      cnt_hw = t2cru_pkg::CNT_TOP;
    end else if (step) begin
      cnt_hw = down_dir ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
    end
    // a software byte write beats the counting logic
    cnt_d = cnt_hw;
    if (wr_clo) begin
      cnt_d[7:0] = reg_wdata;
    end
    if (wr_chi) begin
      cnt_d[15:8] = reg_wdata;
    end
    rcap_d = rcap_q;
    if (wr_rlo) begin
      rcap_d[7:0] = reg_wdata;
    end
    if (wr_rhi) begin
      rcap_d[15:8] = reg_wdata;
    end
    if (do_cap) begin
      rcap_d = cnt_q;
    end
    ctl_d = wr_ctl ? reg_wdata : ctl_q;
    ctl_d[t2cru_pkg::CTL_OVF] = ctl_d[t2cru_pkg::CTL_OVF] | tf_set;
    ctl_d[t2cru_pkg::CTL_EXT] = ctl_d[t2cru_pkg::CTL_EXT] | exf_set;
    mode_d = wr_mode ? reg_wdata[1:0] : mode_q;
    ckc_d  = wr_ckc ? (reg_wdata & t2cru_pkg::CKC_MASK) : ckc_q;
    clko_d = clko_q ^ (mode_q[t2cru_pkg::MODE_OE] && ovf_ev);
    rx_d = ctl_q[t2cru_pkg::CTL_RCLK] ? ovf_ev : t1_ovf;
    tx_d = ctl_q[t2cru_pkg::CTL_TRANSMIT_CLOCK_SELECT] ? ovf_ev : t1_ovf;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pre_q  <= t2cru_pkg::RST_NIB;
      cnt_q  <= t2cru_pkg::RST_WORD;
      rcap_q <= t2cru_pkg::RST_WORD;
      ctl_q  <= t2cru_pkg::RST_BYTE;
      mode_q <= t2cru_pkg::RST_MODE;
      ckc_q  <= t2cru_pkg::RST_BYTE;
      clko_q <= 1'b0;
      rx_q   <= 1'b0;
      tx_q   <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      cnt_q  <= cnt_d;
      rcap_q <= rcap_d;
      ctl_q  <= ctl_d;
      mode_q <= mode_d;
      ckc_q  <= ckc_d;
      clko_q <= clko_d;
      rx_q   <= rx_d;
      tx_q   <= tx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read and interrupt status

  always_comb begin
    ev = 4'h0;
    ev[t2cru_pkg::EV_OVF] = ovf_ev;
    ev[t2cru_pkg::EV_EXT] = exf_set;
    ev[t2cru_pkg::EV_CAP] = do_cap;
    ev[t2cru_pkg::EV_RLD] = do_rld;
    // new events win over a write-one-to-clear in the same cycle
    stat_d = (stat_q & ~(wr_stat ? reg_wdata[3:0] : 4'h0)) | ev;
    mask_d = wr_mask ? reg_wdata[3:0] : mask_q;
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        t2cru_pkg::ADDR_CTRL:     rdata_d = ctl_q;
        t2cru_pkg::ADDR_MODE:     rdata_d = {6'h00, mode_q};
        t2cru_pkg::ADDR_RCAP_LO:  rdata_d = rcap_q[7:0];
        t2cru_pkg::ADDR_RCAP_HI:  rdata_d = rcap_q[15:8];
        t2cru_pkg::ADDR_CNT_LO:   rdata_d = cnt_q[7:0];
        t2cru_pkg::ADDR_CNT_HI:   rdata_d = cnt_q[15:8];
        t2cru_pkg::ADDR_CLKCTL:   rdata_d = ckc_q;
        t2cru_pkg::ADDR_IRQ_STAT: rdata_d = {4'h0, stat_q};
        t2cru_pkg::ADDR_IRQ_MASK: rdata_d = {4'h0, mask_q};
        default:                  rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stat_q  <= t2cru_pkg::RST_NIB;
      mask_q  <= t2cru_pkg::RST_NIB;
      rdata_q <= t2cru_pkg::RST_BYTE;
    end else begin
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata    = rdata_q;
  assign clk_out      = clko_q;
  assign clk_out_oe_n = !mode_q[t2cru_pkg::MODE_OE];
  assign rx_tick      = rx_q;
  assign tx_tick      = tx_q;
  assign timer_irq = (ctl_q[t2cru_pkg::CTL_OVF] | ctl_q[t2cru_pkg::CTL_EXT])
                     && ckc_q[t2cru_pkg::CKC_IEN];
  assign irq = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_ovf_flag;
    tf_set |=> ctl_q[t2cru_pkg::CTL_OVF];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("overflow flag not set");

  property p_ovf_flag_baud;
    (baud && !wr_ctl && !ctl_q[t2cru_pkg::CTL_OVF]) |=>
      !ctl_q[t2cru_pkg::CTL_OVF];
  endproperty
  a_ovf_flag_baud: assert property (p_ovf_flag_baud)
    else $error("overflow flag set in baud mode");

  property p_ext_flag;
    (pins.trig_fall && ctl_q[t2cru_pkg::CTL_EXEN] &&
     !mode_q[t2cru_pkg::MODE_DOWN_COUNT_ENABLE]) |=> ctl_q[t2cru_pkg::CTL_EXT];
  endproperty
  a_ext_flag: assert property (p_ext_flag)
    else $error("external flag not set");

  property p_irq_req;
    ($rose(ctl_q[t2cru_pkg::CTL_EXT]) && ckc_q[t2cru_pkg::CKC_IEN]) |->
      timer_irq;
  endproperty
  a_irq_req: assert property (p_irq_req)
    else $error("timer request missing");

  property p_irq_gate;
    !ckc_q[t2cru_pkg::CKC_IEN] |-> !timer_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("timer request while disabled");

  property p_rx_base;
    ovf_ev && ctl_q[t2cru_pkg::CTL_RCLK] |=> rx_tick;
  endproperty
  a_rx_base: assert property (p_rx_base)
    else $error("receive tick missing");

  property p_tx_base;
    t1_ovf && !ctl_q[t2cru_pkg::CTL_TRANSMIT_CLOCK_SELECT] |=> tx_tick;
  endproperty
  a_tx_base: assert property (p_tx_base)
    else $error("transmit tick missing");

  property p_run_hold;
    (!ctl_q[t2cru_pkg::CTL_RUN] && !wr_clo && !wr_chi && !trig_act) |=>
      $stable(cnt_q);
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("counter moved while stopped");

  property p_slow_rate;
    (pre_tick && !ckc_q[t2cru_pkg::CKC_PRESC] && !wr_ckc &&
     ctl_q[t2cru_pkg::CTL_RUN] && !wr_ctl) |=> !pre_tick [*8];
  endproperty
  a_slow_rate: assert property (p_slow_rate)
    else $error("slow prescale too fast");

  property p_capture;
    do_cap |=> (rcap_q == $past(cnt_q));
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture value wrong");

  property p_reload;
    (up_ovf && !capmode && !wr_clo && !wr_chi) |=>
      (cnt_q == $past(rcap_q));
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload value wrong");

  property p_baud_no_cap;
    (baud && trig_en && !wr_rlo && !wr_rhi) |=> $stable(rcap_q);
  endproperty
  a_baud_no_cap: assert property (p_baud_no_cap)
    else $error("capture in baud mode");

  property p_clkout;
    (mode_q[t2cru_pkg::MODE_OE] && ovf_ev) |=> (clk_out != $past(clk_out));
  endproperty
  a_clkout: assert property (p_clkout)
    else $error("clock out did not toggle");

  property p_down;
    (down_dir && step && !dn_hit && !do_rld && !wr_clo && !wr_chi) |=>
      (cnt_q == $past(cnt_q) - 16'h0001);
  endproperty
  a_down: assert property (p_down)
    else $error("down count wrong");

  c_reload:  cover property (up_ovf && !capmode);
  c_capture: cover property (do_cap);
  c_baud:    cover property (baud && ovf_ev);
  c_down:    cover property (dn_hit);

endmodule

// ---- testbench/t2cru_partner.sv ----
// t2cru_partner: far-side model of trigger pin, count pin and serial port
`timescale 1ns/1ps
module t2cru_partner (
  // clock
  input  logic clk_sys,
  // pins toward the timer
  output logic trig_pin,
  output logic count_pin,
  // serial port time base
  output logic t1_ovf,
  input  logic rx_tick,
  input  logic tx_tick
);
  int rx_cnt;
  int tx_cnt;

  initial begin
    trig_pin  = 1'b1;
    count_pin = 1'b1;
    t1_ovf    = 1'b0;
    rx_cnt    = 0;
    tx_cnt    = 0;
  end

  always @(posedge clk_sys) begin
    if (rx_tick === 1'b1)
      rx_cnt <= rx_cnt + 1;
    if (tx_tick === 1'b1)
      tx_cnt <= tx_cnt + 1;
  end

  // cleared between edges so the counting process never collides
  task automatic clr();
    @(negedge clk_sys);
    rx_cnt = 0;
    tx_cnt = 0;
  endtask

  // 3 cycles per level, above the 2-cycle synchroniser minimum
  task automatic pin_fall(input bit on_count);
    @(posedge clk_sys);
    if (on_count)
      count_pin <= 1'b0;
    else
      trig_pin <= 1'b0;
    repeat (3) @(posedge clk_sys);
    count_pin <= 1'b1;
    trig_pin  <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  // holds the trigger level, used as count direction
  task automatic trig_level(input logic lvl);
    @(posedge clk_sys);
    trig_pin <= lvl;
  endtask

  task automatic pulse_t1(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      t1_ovf <= 1'b1;
      @(posedge clk_sys);
      t1_ovf <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask
endmodule

// ---- testbench/t2cru_timer_tb.sv ----
// t2cru_timer_tb: self-checking bench of the timer unit
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module t2cru_timer_tb;
  logic       clk_sys = 1'b0;
  logic       arst_n  = 1'b0;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       trig_pin;
  logic       count_pin;
  logic       clk_out;
  logic       clk_out_oe_n;
  logic       t1_ovf;
  logic       rx_tick;
  logic       tx_tick;
  logic       timer_irq;
  logic       irq;
  int         fail_count = 0;
  int         num_checks = 0;
  int         cyc = 0;

  always #25 clk_sys = ~clk_sys;

  t2cru_timer uut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig_pin(trig_pin), .count_pin(count_pin),
    .clk_out(clk_out), .clk_out_oe_n(clk_out_oe_n), .t1_ovf(t1_ovf),
    .rx_tick(rx_tick), .tx_tick(tx_tick), .timer_irq(timer_irq), .irq(irq));

  t2cru_partner part (.clk_sys(clk_sys), .trig_pin(trig_pin),
    .count_pin(count_pin), .t1_ovf(t1_ovf), .rx_tick(rx_tick),
    .tx_tick(tx_tick));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask

  // bounded wait so a dead interrupt cannot hang the run
  task automatic wait_irq(input int n);
    for (int i = 0; i < n && timer_irq !== 1'b1; i++)
      tick(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] map [10] = '{8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd,
                             8'he0, 8'he1, 8'he2, 8'h50};
    foreach (map[i])
      chk_rd(map[i], 8'h00);
    `CHK(clk_out_oe_n, 1'b1)
    wr(8'h50, 8'hff);
    chk_rd(8'h50, 8'h00);
    wr(8'hc9, 8'hff);
    chk_rd(8'hc9, 8'h03);
    wr(8'hc9, 8'h00);
  endtask

  task automatic t_overflow();
    logic [7:0] v1;
    logic [7:0] v2;
    wr(8'he0, 8'h21);
    wr(8'he2, 8'h01);
    wr(8'hca, 8'h00);
    wr(8'hcb, 8'h80);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h04);
    wait_irq(100);
    chk_rd(8'hc8, 8'h84);
    `CHK(irq, 1'b1)
    wr(8'hc8, 8'h00);
    chk_rd(8'hcd, 8'h80);
    rd(8'hcc, v1);
    tick(30);
    rd(8'hcc, v2);
    `CHK(v2, v1)
    `CHK(timer_irq, 1'b0)
    wr(8'he2, 8'h00);
    tick(2);
    `CHK(irq, 1'b0)
    wr(8'he2, 8'h01);
    wr(8'he1, 8'h01);
    tick(2);
    `CHK(irq, 1'b0)
    wr(8'he0, 8'h20);
    wr(8'hc8, 8'h80);
    tick(2);
    `CHK(timer_irq, 1'b0)
    wr(8'he0, 8'h21);
    tick(2);
    `CHK(timer_irq, 1'b1)
    wr(8'hc8, 8'h00);
  endtask

  task automatic t_capture();
    wr(8'hc8, 8'h09);
    wr(8'hcc, 8'h34);
    wr(8'hcd, 8'h12);
    part.pin_fall(1'b0);
    wait_irq(20);
    chk_rd(8'hca, 8'h34);
    chk_rd(8'hcb, 8'h12);
    chk_rd(8'hc8, 8'h49);
    `CHK(timer_irq, 1'b1)
    wr(8'hc8, 8'h08);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    part.pin_fall(1'b0);
    tick(4);
    chk_rd(8'hcc, 8'h34);
    chk_rd(8'hcd, 8'h12);
    wr(8'hc8, 8'h38);
    wr(8'hcd, 8'h00);
    part.pin_fall(1'b0);
    tick(4);
    chk_rd(8'hcd, 8'h00);
    wr(8'hc8, 8'h06);
    wr(8'hcc, 8'h00);
    repeat (3) part.pin_fall(1'b1);
    tick(4);
    chk_rd(8'hcc, 8'h03);
    wr(8'hc8, 8'h00);
  endtask

  task automatic t_baud();
    wr(8'hc9, 8'h02);
    wr(8'hca, 8'hfe);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    part.clr();
    wr(8'hc8, 8'h34);
    for (int i = 0; i < 200 && part.rx_cnt < 5; i++)
      tick(1);
    // five overflows leave the output toggled an odd number of times
    `CHK(clk_out, 1'b1)
    `CHK(part.rx_cnt >= 4, 1'b1)
    `CHK(part.rx_cnt == part.tx_cnt, 1'b1)
    chk_rd(8'hc8, 8'h34);
    `CHK(clk_out_oe_n, 1'b0)
    wr(8'hc8, 8'h14);
    part.clr();
    part.pulse_t1(5);
    tick(3);
    `CHK(part.rx_cnt, 5)
    `CHK(part.tx_cnt > 0, 1'b1)
    wr(8'hc8, 8'h00);
    wr(8'hc9, 8'h00);
    tick(2);
    `CHK(clk_out_oe_n, 1'b1)
  endtask

  // slow prescale, trigger held low: 7 -> 6 -> 5 matches reload, wraps
  task automatic t_down();
    wr(8'hc9, 8'h01);
    wr(8'hca, 8'h05);
    wr(8'hcb, 8'h00);
    wr(8'hcc, 8'h07);
    wr(8'hcd, 8'h00);
    part.trig_level(1'b0);
    tick(4);
    wr(8'he0, 8'h01);
    wr(8'hc8, 8'h04);
    wait_irq(100);
    chk_rd(8'hc8, 8'h84);
    wr(8'hc8, 8'h00);
    chk_rd(8'hcc, 8'hff);
    chk_rd(8'hcd, 8'hff);
    part.trig_level(1'b1);
    wr(8'hc9, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_overflow();
    t_capture();
    t_baud();
    t_down();
    tally_and_finish();
  end
endmodule
